// ===== logic/board_power_defs.svh
// Register layout, reset values and timing counts of the board power control.
// Assumes the including file is compiled as SystemVerilog.
`ifndef BOARD_POWER_DEFS_SVH
`define BOARD_POWER_DEFS_SVH
`define PWR_OFF_BIT 0
`define IRQ_CLR_BIT 1
`define CYCLED_BIT 2
`define DOWN_REQ_BIT 3
`define SOFT_RST_BIT 4
`define CTRL_W 5
`define CTRL_RESET 5'h00
`define BUTTON_FILTER 4'h3
`endif

// ===== logic/board_power_pkg.sv
// Types shared by the board power control files.
// Assumes board_power_defs.svh is on the include path.
package board_power_pkg;
  typedef enum logic [1:0] {PB_DEAD, PB_STANDBY, PB_ON} pb_state_t;
  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [4:0] wdata;
  } reg_req_t;
endpackage

// ===== logic/button_edge.sv
// Pushbutton press detector: a short filter that gives one press pulse.
// Assumes the button input is already synchronous to clk_sys.
`include "board_power_defs.svh"
module button_edge
  import board_power_pkg::*;
#(
  parameter int FILTER = `BUTTON_FILTER
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic button,
  output logic press
);
  logic [3:0] cnt_r, cnt_nxt;
  logic stable_r, stable_nxt;
  logic press_r, press_nxt;

  // The counter is four bits wide, so longer filters cannot be served
  if (FILTER < 1 || FILTER > 15)
  begin : g_bad_filter
    $error("FILTER out of range");
  end

  // Filter rejects contact bounce of FILTER cycles or shorter
  always_comb
  begin
    cnt_nxt = cnt_r;
    stable_nxt = stable_r;
    press_nxt = 1'b0;
    if (button == stable_r)
      cnt_nxt = 4'h0;
    else if (cnt_r == 4'(FILTER))
    begin
      cnt_nxt = 4'h0;
      stable_nxt = button;
      press_nxt = button;
    end
    else
      cnt_nxt = cnt_r + 4'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_r <= 4'h0;
      stable_r <= 1'b0;
      press_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      stable_r <= stable_nxt;
      press_r <= press_nxt;
    end
  end

  assign press = press_r;
endmodule

// ===== logic/board_power_control.sv
// Board power control register and front-panel pushbutton sequencer.
// Assumes a synchronous register port on clk_sys and synchronous pins.
`include "board_power_defs.svh"
module board_power_control
  import board_power_pkg::*;
#(
  parameter bit HAS_BUTTON = 1'b1,
  parameter bit HAS_SOFT_RESET = 1'b1,
  parameter int FILTER = `BUTTON_FILTER
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire reg_req_t req,
  output logic [4:0] rdata,
  output logic rvalid,
  input wire logic standby_ok,
  input wire logic main_ok,
  input wire logic seated,
  input wire logic button,
  output logic main_power_off,
  output logic power_event_irq,
  output logic board_reset
);
  logic [4:0] ctrl_r, ctrl_nxt;
  logic locked_r, locked_nxt;
  logic main_seen_r, main_seen_nxt;
  logic [4:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  pb_state_t st_r, st_nxt;
  logic press;
  logic access_ok;
  logic wr_hit;
  logic rd_hit;
  logic standby_press;

  // Field map and button filter counter are fixed at these sizes
  if (`CTRL_W != 5 || FILTER < 1 || FILTER > 15)
  begin : g_bad_params
    $error("board power control parameters out of range");
  end

  // One decode for both directions keeps the lockout consistent
  function automatic logic bus_hit(input reg_req_t q, input logic ok,
    input logic want_wr);
    begin
      return q.cs && ok && (want_wr ? q.wr : q.rd);
    end
  endfunction

  // Absent features read as zero, whatever the flops hold
  function automatic logic [4:0] read_view(input logic [4:0] r);
    logic [4:0] v;
    begin
      v = r;
      if (!HAS_BUTTON)
        v[`DOWN_REQ_BIT] = 1'b0;
      if (!HAS_SOFT_RESET)
        v[`SOFT_RST_BIT] = 1'b0;
      return v;
    end
  endfunction

  button_edge #(.FILTER(FILTER)) u_btn (
    .clk_sys(clk_sys),
    .rst(rst),
    .button(button),
    .press(press)
  );

  // Register port answers only with main power and not locked out
  assign access_ok = main_ok && !locked_r;

  // Select arrives decoded from I/O or memory space, the system's choice
  assign wr_hit = bus_hit(req, access_ok, 1'b1);
  assign rd_hit = bus_hit(req, access_ok, 1'b0);
  assign standby_press = press && st_r == PB_STANDBY && standby_ok &&
    !main_ok;

  // Pushbutton supply state tracks the two supply levels; a press in standby forces PB_ON
  always_comb
  begin
    if (!standby_ok)
      st_nxt = PB_DEAD;
    else if (!main_ok)
      st_nxt = PB_STANDBY;
    else
      st_nxt = PB_ON;
    if (standby_ok && !main_ok && press)
      st_nxt = PB_ON;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      st_r <= PB_DEAD;
    else
      st_r <= st_nxt;
  end

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    locked_nxt = locked_r;
    main_seen_nxt = main_ok;
    // Removal with an unseated board releases the lockout
    if (!seated)
      locked_nxt = 1'b0;
    if (wr_hit)
    begin
      ctrl_nxt[`PWR_OFF_BIT] = req.wdata[`PWR_OFF_BIT];
      ctrl_nxt[`IRQ_CLR_BIT] = req.wdata[`IRQ_CLR_BIT];
      ctrl_nxt[`SOFT_RST_BIT] = HAS_SOFT_RESET &&
        req.wdata[`SOFT_RST_BIT];
      if (req.wdata[`PWR_OFF_BIT])
        locked_nxt = 1'b1;
    end
    // Flags held clear while bit 1 is one; software must rewrite zero
    if (ctrl_nxt[`IRQ_CLR_BIT])
    begin
      ctrl_nxt[`CYCLED_BIT] = 1'b0;
      ctrl_nxt[`DOWN_REQ_BIT] = 1'b0;
    end
    else
    begin
      if (main_ok && !main_seen_r)
        ctrl_nxt[`CYCLED_BIT] = 1'b1;
      if (HAS_BUTTON && press && st_r == PB_ON && main_ok)
        ctrl_nxt[`DOWN_REQ_BIT] = 1'b1;
    end
    if (standby_press)
    begin
      ctrl_nxt[`PWR_OFF_BIT] = 1'b0;
      locked_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctrl_r <= `CTRL_RESET;
      locked_r <= 1'b0;
      // Taken as seen, so a reset with power up never fakes a power cycle
      main_seen_r <= 1'b1;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      locked_r <= locked_nxt;
      main_seen_r <= main_seen_nxt;
    end
  end

  // Read port: rdata holds the last answer, rvalid pulses once
  always_comb
  begin
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    if (rd_hit)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt = read_view(ctrl_r);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rdata_r <= 5'h00;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign rdata = rdata_r;
  assign rvalid = rvalid_r;
  assign main_power_off = ctrl_r[`PWR_OFF_BIT];
  assign board_reset = ctrl_r[`SOFT_RST_BIT];
  assign power_event_irq = !ctrl_r[`IRQ_CLR_BIT] &&
    (ctrl_r[`CYCLED_BIT] || ctrl_r[`DOWN_REQ_BIT]);

  a_read_lockout: assert property (@(posedge clk_sys) disable iff (rst)
    locked_r |=> !rvalid)
    else $error("read answered while locked");
  a_no_power_read: assert property (@(posedge clk_sys) disable iff (rst)
    (req.cs && req.rd && !main_ok) |=> !rvalid)
    else $error("read answered without main power");
  a_clear_flags: assert property (@(posedge clk_sys) disable iff (rst)
    (req.cs && req.wr && access_ok && req.wdata[1]) |=>
    !ctrl_r[2] && !ctrl_r[3] && !power_event_irq)
    else $error("clear left flags set");
  a_irq_level: assert property (@(posedge clk_sys) disable iff (rst)
    power_event_irq == (!ctrl_r[1] && (ctrl_r[2] || ctrl_r[3])))
    else $error("interrupt level wrong");
  a_reset_vals: assert property (@(posedge clk_sys)
    rst |=> ctrl_r == 5'h00 && !board_reset)
    else $error("reset values wrong");
  a_power_write: assert property (@(posedge clk_sys) disable iff (rst)
    (req.cs && req.wr && access_ok && !(st_r == PB_STANDBY && press)) |=>
    main_power_off == $past(req.wdata[0]))
    else $error("power bit not written");
  a_press_down_req: assert property (@(posedge clk_sys) disable iff (rst)
    (press && st_r == PB_ON && main_ok && !ctrl_nxt[1]) |=>
    ctrl_r[3] ##0 power_event_irq)
    else $error("press did not request power down");
  a_press_standby: assert property (@(posedge clk_sys) disable iff (rst)
    (press && st_r == PB_STANDBY && standby_ok && !main_ok) |=>
    !main_power_off && st_r == PB_ON)
    else $error("standby press did not enable power");
  a_dead_state: assert property (@(posedge clk_sys) disable iff (rst)
    !standby_ok |=> st_r == PB_DEAD)
    else $error("state left 0 without supplies");
  a_soft_reset: assert property (@(posedge clk_sys) disable iff (rst)
    (req.cs && req.wr && access_ok) |=>
    board_reset == (HAS_SOFT_RESET && $past(req.wdata[4])))
    else $error("soft reset bit wrong");

  c_read: cover property (@(posedge clk_sys) rvalid);
  c_lock: cover property (@(posedge clk_sys) !locked_r ##1 locked_r);
  c_irq: cover property (@(posedge clk_sys) power_event_irq);
  c_pwr_on: cover property (@(posedge clk_sys) st_r == PB_STANDBY
    ##1 st_r == PB_ON);
  c_down_req: cover property (@(posedge clk_sys) ctrl_r[3]);

  // Read answer carries the register as it stood when taken
  a_read_answer: assert property (@(posedge clk_sys) disable iff (rst)
    rd_hit |=> rvalid && rdata == read_view($past(ctrl_r)))
    else $error("read answer wrong");
  a_read_silent: assert property (@(posedge clk_sys) disable iff (rst)
    !rd_hit |=> !rvalid)
    else $error("read answer without request");
  // Lockout set by power-off write, kept until unseated or standby press
  a_lock_set: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_hit && req.wdata[0]) |=> locked_r)
    else $error("power-off write did not lock");
  a_lock_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (locked_r && seated && !standby_press) |=> locked_r)
    else $error("lockout dropped while seated");
  a_unseat_free: assert property (@(posedge clk_sys) disable iff (rst)
    (!seated && !wr_hit) |=> !locked_r)
    else $error("lockout kept after removal");
  a_refused_write: assert property (@(posedge clk_sys) disable iff (rst)
    (req.cs && req.wr && !access_ok && !standby_press) |=>
    ctrl_r[0] == $past(ctrl_r[0]) && ctrl_r[1] == $past(ctrl_r[1]) &&
    ctrl_r[4] == $past(ctrl_r[4]))
    else $error("refused write changed the register");
  a_clear_holds: assert property (@(posedge clk_sys) disable iff (rst)
    ctrl_r[1] |-> !ctrl_r[2] && !ctrl_r[3] && !power_event_irq)
    else $error("flags set while clear bit is one");
  // Flags are sticky until cleared, and set only by their own events
  a_cycled_set: assert property (@(posedge clk_sys) disable iff (rst)
    (main_ok && !main_seen_r && !ctrl_nxt[1]) |=> ctrl_r[2])
    else $error("power cycle not flagged");
  a_cycled_keep: assert property (@(posedge clk_sys) disable iff (rst)
    (ctrl_r[2] && !ctrl_nxt[1]) |=> ctrl_r[2])
    else $error("power cycle flag lost");
  a_down_keep: assert property (@(posedge clk_sys) disable iff (rst)
    (ctrl_r[3] && !ctrl_nxt[1]) |=> ctrl_r[3])
    else $error("power down request lost");
  a_down_cause: assert property (@(posedge clk_sys) disable iff (rst)
    (!ctrl_r[3] && !(press && main_ok)) |=> !ctrl_r[3])
    else $error("power down request without press");
  a_reset_flags: assert property (@(posedge clk_sys)
    rst |=> !ctrl_r[3] && !ctrl_r[1] && !rvalid)
    else $error("reset left flags or answer set");
endmodule

// ===== testbench/slot_supply_model.sv
// Slot rails model: standby rail and switched main rail.
// Assumes the bench switches standby and the block drives the power switch.
module slot_supply_model(
  input wire logic clk_sys,
  input wire logic standby_on,
  input wire logic main_power_off,
  output logic standby_ok,
  output logic main_ok = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  assign standby_ok = standby_on;
  // Main rail lags the switch a cycle, as a soft-start switch would
  always @(posedge clk_sys)
  begin
    main_ok <= standby_on && !main_power_off;
  end
endmodule

// ===== testbench/testbench.sv
// Self-checking bench of the board power control register and button.
// Assumes the slot rails model drives both supply inputs.
module testbench;
  import board_power_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst, rvalid, standby_on, standby_ok, main_ok, seated;
  logic button, main_power_off, power_event_irq, board_reset;
  logic [4:0] rdata;
  reg_req_t req;
  int fails = 0;
  int compares = 0;
  board_power_control dut_u(.clk_sys(clk_sys), .rst(rst), .req(req),
    .rdata(rdata), .rvalid(rvalid), .standby_ok(standby_ok),
    .main_ok(main_ok), .seated(seated), .button(button),
    .main_power_off(main_power_off), .power_event_irq(power_event_irq),
    .board_reset(board_reset));
  slot_supply_model slot_u(.clk_sys(clk_sys), .standby_on(standby_on),
    .main_power_off(main_power_off), .standby_ok(standby_ok),
    .main_ok(main_ok));
  task automatic end_of_test;
    $display("Mismatches %0d of %0d compares", fails, compares);
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] d);
    req <= '{cs:1'b1, rd:1'b0, wr:1'b1, wdata:d};
    @(posedge clk_sys);
    req <= '0;
    @(posedge clk_sys);
  endtask
  // A refused read is judged on the missing answer only
  task automatic rchk(input logic vld, input logic [4:0] exp);
    logic ok;
    logic [4:0] v;
    req <= '{cs:1'b1, rd:1'b1, wr:1'b0, wdata:5'h00};
    @(posedge clk_sys);
    req <= '0;
    #1;
    ok = rvalid;
    v = rdata;
    if (vld)
      check({2'h0, ok, v}, {3'h1, exp});
    else
      check({7'h00, ok}, 8'h00);
    @(posedge clk_sys);
  endtask
  // Held well past the filter so one press is seen, then released
  task automatic press;
    button <= 1'b1;
    repeat (10) @(posedge clk_sys);
    button <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask
  task automatic t_dead;
    press;
    check({7'h00, power_event_irq}, 8'h00);
    check({7'h00, main_power_off}, 8'h00);
    rchk(1'b0, 5'h00);
    standby_on <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic t_cycle;
    rchk(1'b1, 5'h04);
    check({7'h00, power_event_irq}, 8'h01);
    wr(5'h02);
    check({7'h00, power_event_irq}, 8'h00);
    rchk(1'b1, 5'h02);
    wr(5'h00);
    rchk(1'b1, 5'h00);
  endtask
  task automatic t_soft;
    wr(5'h10);
    check({7'h00, board_reset}, 8'h01);
    rchk(1'b1, 5'h10);
    wr(5'h00);
    check({7'h00, board_reset}, 8'h00);
  endtask
  task automatic t_button;
    press;
    rchk(1'b1, 5'h08);
    check({7'h00, power_event_irq}, 8'h01);
    wr(5'h02);
    wr(5'h00);
  endtask
  task automatic t_off;
    wr(5'h01);
    check({7'h00, main_power_off}, 8'h01);
    repeat (2) @(posedge clk_sys);
    rchk(1'b0, 5'h00);
    press;
    check({7'h00, main_power_off}, 8'h00);
    rchk(1'b1, 5'h04);
    wr(5'h02);
    wr(5'h00);
  endtask
  task automatic t_reset;
    wr(5'h10);
    press;
    rchk(1'b1, 5'h18);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check({7'h00, board_reset}, 8'h00);
    rchk(1'b1, 5'h00);
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    fails++;
    end_of_test;
  end
  initial
  begin
    rst = 1'b1;
    standby_on = 1'b0;
    seated = 1'b1;
    button = 1'b0;
    req = '0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_dead;
    t_cycle;
    t_soft;
    t_button;
    t_off;
    t_reset;
    end_of_test;
  end
endmodule
